// ### design/slc_level_sel.sv
/*
  Level selector: picks the run or sleep level code for the regulator
  and flags bypass. Purely combinational; registered by the caller.
*/
`timescale 1ns/10ps
module slc_level_sel (
  input  wire logic              save_i,   // Power-save enable
  input  wire logic [2:0]        run_i,    // Run level code
  input  wire logic [2:0]        sleep_i,  // Sleep level code
  input  wire slc_pkg::slc_mode_e mode_i,  // Core mode
  output logic                   bypass_o, // Pass battery through
  output logic [2:0]             level_o   // Selected level code
);
  import slc_pkg::*;

  // Idle and stop take the sleep code, fast and slow the run code
  always_comb begin
    bypass_o = ~save_i;
    if (mode_i == SLC_IDLE || mode_i == SLC_STOP) begin
      level_o = sleep_i;
    end else begin
      level_o = run_i;
    end
  end
endmodule

// ### design/slc_pkg.sv
/*
  Package for the supply-level control register pair: addresses, field
  positions, reset values and the carrier structs shared by the block.
  Assumes an 8-bit special-register bus with byte-wide accesses.
*/
package slc_pkg;
  localparam logic [7:0] SLC_OPT_ADDR      = 8'h94;
  localparam logic [7:0] SLC_SUP_ADDR      = 8'ha7;
  localparam logic [7:0] SLC_SUP_RESET     = 8'h22;
  localparam logic [2:0] SLC_DIV_RESET     = 3'h0;
  localparam logic [3:0] SLC_OPT_LOW_RESET = 4'h1;
  localparam int         SLC_SAVE_BIT      = 6;
  localparam int         SLC_RUN_LSB       = 3;
  localparam int         SLC_SLEEP_LSB     = 0;
  localparam int         SLC_DIV_LSB       = 4;
  localparam int         SLC_CMP_BIT       = 7;
  localparam logic [2:0] SLC_DIV_OFF       = 3'h0;

  // Operating modes of the processor core
  typedef enum logic [1:0] {
    SLC_FAST = 2'b00,
    SLC_SLOW = 2'b01,
    SLC_IDLE = 2'b11,
    SLC_STOP = 2'b10
  } slc_mode_e;

  // Register bus request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } slc_bus_s;

  // Drive toward the analog regulator and comparator
  typedef struct packed {
    logic       bypass;
    logic [2:0] level;
    logic       cmp_en;
    logic [2:0] divider;
  } slc_ana_s;
endpackage

// ### design/slc_regs.sv
/*
  Supply-level control registers: supply control and the comparator
  fields of the option register, on the special-register bus.
  Assumes bus strobes are synchronous one-cycle pulses and that the
  comparator output is synchronous to the core clock.
*/
// Overview of operation
// - Save enable resets zero; zero means bypass
// - Save enable one gives reduced regulator level
// - Run level code in bits five to three
// - Sleep level code in bits two to zero
// - Supply control resets 0x22, frozen in emulation
// - Divider code zero turns comparator off
// - Nonzero divider code scales battery to comparator
// - Option bit seven reads compare result
// - Fast and slow are the run states
`timescale 1ns/10ps
module slc_regs (
  input  wire logic               CORE_CLK_I,  // Core clock, 20 MHz
  input  wire logic               SYS_RST_I,   // Async reset, active high
  input  wire slc_pkg::slc_bus_s  BUS_I,       // Register bus request
  input  wire slc_pkg::slc_mode_e MODE_I,      // Core operating mode
  input  wire logic               EMU_MODE_I,  // In-circuit emulation
  input  wire logic               CMP_OUT_I,   // Comparator output
  input  wire logic [3:0]         OPT_LOW_I,   // Other option bits 3..0
  output logic [7:0]              RDATA_O,     // Read data
  output slc_pkg::slc_ana_s       ANA_O        // Regulator/comparator drive
);
  import slc_pkg::*;

  logic       save_r;
  logic [2:0] run_r;
  logic [2:0] sleep_r;
  logic [2:0] div_r;
  logic       cmp_r;
  logic       bypass_nxt;
  logic [2:0] level_nxt;
  logic       sup_wr;
  logic       opt_wr;

  assign sup_wr = BUS_I.wr && BUS_I.addr == SLC_SUP_ADDR && !EMU_MODE_I;
  assign opt_wr = BUS_I.wr && BUS_I.addr == SLC_OPT_ADDR;

  // Supply control register; emulation ignores writes and holds reset
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      save_r  <= SLC_SUP_RESET[SLC_SAVE_BIT];
      run_r   <= SLC_SUP_RESET[SLC_RUN_LSB +: 3];
      sleep_r <= SLC_SUP_RESET[SLC_SLEEP_LSB +: 3];
    end else if (EMU_MODE_I) begin
      save_r  <= SLC_SUP_RESET[SLC_SAVE_BIT];
      run_r   <= SLC_SUP_RESET[SLC_RUN_LSB +: 3];
      sleep_r <= SLC_SUP_RESET[SLC_SLEEP_LSB +: 3];
    end else if (sup_wr) begin
      save_r  <= BUS_I.wdata[SLC_SAVE_BIT];
      run_r   <= BUS_I.wdata[SLC_RUN_LSB +: 3];
      sleep_r <= BUS_I.wdata[SLC_SLEEP_LSB +: 3];
    end
  end

  // Divider select in the option register
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      div_r <= SLC_DIV_RESET;
    end else if (opt_wr) begin
      div_r <= BUS_I.wdata[SLC_DIV_LSB +: 3];
    end
  end

  // Comparator result sampled; forced low while comparator is off
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      cmp_r <= 1'b0;
    end else begin
      cmp_r <= (div_r != SLC_DIV_OFF) && CMP_OUT_I;
    end
  end

  slc_level_sel u_sel (
    .save_i   (save_r),
    .run_i    (run_r),
    .sleep_i  (sleep_r),
    .mode_i   (MODE_I),
    .bypass_o (bypass_nxt),
    .level_o  (level_nxt)
  );

  // Registered drive to the analog side
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ANA_O <= '{bypass: 1'b1, level: 3'h0, cmp_en: 1'b0, divider: 3'h0};
    end else begin
      ANA_O.bypass  <= bypass_nxt;
      ANA_O.level   <= level_nxt;
      ANA_O.cmp_en  <= (div_r != SLC_DIV_OFF);
      ANA_O.divider <= div_r;
    end
  end

  // Read data; unmapped addresses read zero, bit 7 of supply reads zero
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      RDATA_O <= 8'h00;
    end else if (BUS_I.rd && BUS_I.addr == SLC_SUP_ADDR) begin
      RDATA_O <= {1'b0, save_r, run_r, sleep_r};
    end else if (BUS_I.rd && BUS_I.addr == SLC_OPT_ADDR) begin
      RDATA_O <= {cmp_r, div_r, OPT_LOW_I};
    end else begin
      RDATA_O <= 8'h00;
    end
  end

  // Checks: supply control reset value and emulation freeze

  a_reset_value: assert property (
    @(posedge CORE_CLK_I)
    $fell(SYS_RST_I) |->
      {save_r, run_r, sleep_r} == SLC_SUP_RESET[6:0])
    else $error("supply control not at reset value");
  a_reset_drive: assert property (
    @(posedge CORE_CLK_I)
    $fell(SYS_RST_I) |->
      ANA_O.bypass && !ANA_O.cmp_en && ANA_O.level == 3'h0)
    else $error("regulator drive not at reset value");
  a_emu_frozen: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    EMU_MODE_I |=>
      {save_r, run_r, sleep_r} == SLC_SUP_RESET[6:0])
    else $error("supply control changed in emulation");
  a_emu_bypass: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    EMU_MODE_I |=>
      ##1 ANA_O.bypass)
    else $error("regulator not bypassed in emulation");
  a_sup_hold: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    !sup_wr && !EMU_MODE_I |=>
      $stable({save_r, run_r, sleep_r}))
    else $error("supply control changed without a write");

  // Checks: regulator drive from save enable and the level codes

  a_bypass_save: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    !save_r |=>
      ANA_O.bypass)
    else $error("bypass missing while save is off");
  a_save_reduce: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    save_r |=>
      !ANA_O.bypass)
    else $error("bypass while save is on");
  a_run_level: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (MODE_I == SLC_FAST || MODE_I == SLC_SLOW) |=>
      ANA_O.level == $past(run_r))
    else $error("run level not applied");
  a_sleep_level: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (MODE_I == SLC_IDLE || MODE_I == SLC_STOP) |=>
      ANA_O.level == $past(sleep_r))
    else $error("sleep level not applied");
  a_sup_read: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (BUS_I.rd && BUS_I.addr == SLC_SUP_ADDR) |=>
      RDATA_O == {1'b0, $past(save_r), $past(run_r), $past(sleep_r)})
    else $error("supply control not read back");

  // Checks: comparator enable, divider code and compare result

  a_cmp_off: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    div_r == SLC_DIV_OFF |=>
      !ANA_O.cmp_en)
    else $error("comparator on with divider zero");
  a_cmp_on: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    div_r != SLC_DIV_OFF |=>
      ANA_O.cmp_en && ANA_O.divider == $past(div_r))
    else $error("comparator off with divider set");
  a_div_write: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    opt_wr |=>
      ##1 ANA_O.divider == $past(BUS_I.wdata[6:4], 2))
    else $error("divider write not applied");
  a_div_hold: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    !opt_wr |=>
      $stable(div_r))
    else $error("divider changed without a write");
  a_cmp_gate: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    div_r == SLC_DIV_OFF |=>
      !cmp_r)
    else $error("compare result set while comparator off");
  a_cmp_follow: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    div_r != SLC_DIV_OFF |=>
      cmp_r == $past(CMP_OUT_I))
    else $error("compare result does not follow comparator");
  a_cmp_read: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (BUS_I.rd && BUS_I.addr == SLC_OPT_ADDR) |=>
      RDATA_O[7] == $past(cmp_r))
    else $error("compare result not read back");

  // Coverage of the main scenarios

  c_save_on: cover property (@(posedge CORE_CLK_I) $rose(save_r));
  c_div_on: cover property (@(posedge CORE_CLK_I)
    ANA_O.cmp_en && cmp_r);
  c_sleep: cover property (@(posedge CORE_CLK_I)
    save_r && MODE_I == SLC_STOP);
  c_cmp_hit: cover property (@(posedge CORE_CLK_I) cmp_r);
  c_emu_wr: cover property (@(posedge CORE_CLK_I)
    EMU_MODE_I && BUS_I.wr && BUS_I.addr == SLC_SUP_ADDR);
endmodule

// ### test/slc_ana_model.sv
/*
  Behavioural regulator and battery comparator model.
  Assumes the drive struct of the register block; battery level in mV.
*/
`timescale 1ns/10ps
module slc_ana_model #(
  parameter int VBAT_MV = 2750  // Battery level, mV
) (
  input  wire slc_pkg::slc_ana_s ana_i,    // Drive from registers
  output logic                   cmp_o,    // Comparator output
  output int                     vdd_mv_o  // Core supply level
);
  import slc_pkg::*;
  // Bypass passes the battery; else 115/300 up in 11/300 steps
  assign vdd_mv_o = ana_i.bypass ? VBAT_MV :
    VBAT_MV * (115 + 11 * ana_i.level) / 300;
  // Divided battery against 1.2 V; disabled reads low
  assign cmp_o = ana_i.cmp_en &&
    (VBAT_MV * 12 > 1200 * (24 + ana_i.divider));
endmodule

// ### test/supply_level_control_regs_tb_top.sv
/*
  Testbench for the supply-level registers with the analog model.
  Assumes 20 MHz core clock and byte-wide register bus pulses.
*/
`timescale 1ns/10ps
module supply_level_control_regs_tb_top;
  import slc_pkg::*;
  localparam int VBAT = 2750;
  typedef struct packed {
    logic [7:0] wdata;
    slc_mode_e  mode;
    logic       emu;
    logic [7:0] rd;
    logic       bypass;
    logic [2:0] level;
  } slc_row_s;
  logic      clk = 1'b0;
  logic      rst = 1'b1;
  slc_bus_s  bus = '0;
  slc_mode_e mode = SLC_FAST;
  logic      emu = 1'b0;
  logic [7:0] rdata;
  slc_ana_s  ana;
  logic      cmp;
  int        vdd;
  int        num_errors = 0;
  int        total_checks = 0;
  slc_row_s  rows [6] = '{
    '{8'h7d, SLC_FAST, 1'b0, 8'h7d, 1'b0, 3'h7},
    '{8'h7d, SLC_IDLE, 1'b0, 8'h7d, 1'b0, 3'h5},
    '{8'h45, SLC_STOP, 1'b0, 8'h45, 1'b0, 3'h5},
    '{8'h28, SLC_SLOW, 1'b0, 8'h28, 1'b1, 3'h5},
    '{8'hff, SLC_FAST, 1'b0, 8'h7f, 1'b0, 3'h7},
    '{8'h7d, SLC_FAST, 1'b1, 8'h22, 1'b1, 3'h4}};
  // Clock
  always #25 clk = ~clk;
  slc_regs u_slc_regs (.CORE_CLK_I(clk), .SYS_RST_I(rst), .BUS_I(bus),
    .MODE_I(mode), .EMU_MODE_I(emu), .CMP_OUT_I(cmp),
    .OPT_LOW_I(4'ha), .RDATA_O(rdata), .ANA_O(ana));
  slc_ana_model #(.VBAT_MV(VBAT)) u_slc_ana_model (.ana_i(ana),
    .cmp_o(cmp), .vdd_mv_o(vdd));
  task automatic chk_byte(string name, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", name, exp, got);
    end
  endtask
  task automatic chk_ana(slc_ana_s exp);
    total_checks++;
    if (ana !== exp) begin
      num_errors++;
      $display("[ERR] ANA_O exp %h got %h", exp, ana);
    end
  endtask
  // One bus pulse; read data is registered at the taking edge
  task automatic bus_op(logic wr, logic [7:0] addr, logic [7:0] data);
    @(posedge clk);
    #1 bus = '{wr, !wr, addr, data};
    @(posedge clk);
    #1 bus = '0;
  endtask
  task automatic report_and_stop;
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #(50 * 3000);
    num_errors++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    #1 chk_ana('{1'b1, 3'h0, 1'b0, 3'h0});
    chk_byte("RDATA_O", 8'h00, rdata);
    rst = 1'b0;
    bus_op(1'b0, SLC_SUP_ADDR, 8'h00);
    chk_byte("supply", 8'h22, rdata);
    chk_ana('{1'b1, 3'h4, 1'b0, 3'h0});
    bus_op(1'b0, SLC_OPT_ADDR, 8'h00);
    chk_byte("option", 8'h0a, rdata);
    @(posedge clk);
    #1 chk_byte("idle", 8'h00, rdata);
    bus_op(1'b0, 8'h95, 8'h00);
    chk_byte("unmapped", 8'h00, rdata);
    foreach (rows[i]) begin
      mode = rows[i].mode;
      emu = rows[i].emu;
      bus_op(1'b1, SLC_SUP_ADDR, rows[i].wdata);
      @(posedge clk);
      #1 chk_ana('{rows[i].bypass, rows[i].level, 1'b0, 3'h0});
      bus_op(1'b0, SLC_SUP_ADDR, 8'h00);
      chk_byte("supply", rows[i].rd, rdata);
    end
    emu = 1'b0;
    // Every divider code; bit 7 and low bits must not take writes
    for (int c = 0; c < 8; c++) begin
      bus_op(1'b1, SLC_OPT_ADDR, {1'b1, c[2:0], 4'h5});
      @(posedge clk);
      #1 chk_ana('{1'b1, 3'h4, c != 0, c[2:0]});
      bus_op(1'b0, SLC_OPT_ADDR, 8'h00);
      chk_byte("option", {c != 0 && VBAT > 100 * (24 + c), c[2:0], 4'ha},
        rdata);
    end
    // Save written off with run and sleep codes 3, then a mid-run reset
    bus_op(1'b1, SLC_SUP_ADDR, 8'h1b);
    @(posedge clk);
    #1 chk_ana('{1'b1, 3'h3, 1'b1, 3'h7});
    rst = 1'b1;
    @(posedge clk);
    #1 chk_ana('{1'b1, 3'h0, 1'b0, 3'h0});
    chk_byte("RDATA_O", 8'h00, rdata);
    rst = 1'b0;
    bus_op(1'b0, SLC_SUP_ADDR, 8'h00);
    chk_byte("supply", 8'h22, rdata);
    bus_op(1'b0, SLC_OPT_ADDR, 8'h00);
    chk_byte("option", 8'h0a, rdata);
    report_and_stop();
  end
endmodule
